// File: hdl/bpwm_pkg.sv
// constants shared by the bridge PWM output stage
package bpwm_pkg;
	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] OFS_DUTY_HIGH = 8'h00;
	localparam logic [7:0] OFS_CONTROL   = 8'h04;
	localparam logic [7:0] OFS_PERIOD    = 8'h08;
	localparam logic [7:0] OFS_TIMER_CTL = 8'h0C;
	localparam logic [7:0] OFS_DEADBAND  = 8'h10;
	localparam logic [7:0] OFS_SHADOW    = 8'h14;
	localparam logic [7:0] OFS_TIMER     = 8'h18;
	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] RST_PERIOD    = 8'hFF;
	localparam logic [7:0] RST_ZERO8     = 8'h00;
	// ****************************************
	// fields
	// ****************************************
	localparam int         CTL_DIR_BIT   = 7;
	localparam int         CTL_FULL_BIT  = 6;
	localparam int         TMR_ON_BIT    = 2;
	localparam logic [1:0] MODE_PWM      = 2'h3;
	localparam logic [1:0] PS_DIV1       = 2'h0;
	localparam logic [1:0] PS_DIV4       = 2'h1;
	// output configuration field, upper bit is the direction
	localparam logic [1:0] CFG_SINGLE    = 2'h0;
	localparam logic [1:0] CFG_HALF      = 2'h2;
	localparam logic [1:0] CFG_FWD       = 2'h1;
	localparam logic [1:0] CFG_REV       = 2'h3;
	// ****************************************
	// timing: oscillator periods per instruction cycle
	// ****************************************
	localparam int         OSC_PER_INSTR = 4;
	localparam logic [5:0] LAST_DIV1     = 6'(OSC_PER_INSTR - 1);
	localparam logic [5:0] LAST_DIV4     = 6'(OSC_PER_INSTR * 4 - 1);
	localparam logic [5:0] LAST_DIV16    = 6'(OSC_PER_INSTR * 16 - 1);
endpackage

// File: hdl/bpwm_output_stage.sv
// enhanced bridge PWM output stage with AHB-Lite register slave
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps

// Behaviour
// [RULE1] duty is ten bits: high byte register plus control bits 5:4
// [RULE2] duty writes land anytime; shadow loads only at the period match
// [RULE3] duty shadow reads back but ignores software writes
// [RULE4] output clears when shadow and latch equal timer with fine phase bits
// [RULE5] duty longer than the period never clears the output
// [RULE6] period is four clocks times period plus one times prescale 1/4/16
// [RULE7] four output configurations from a two-bit field
// [RULE8] half-bridge drives waveform on A and its complement on B
// [RULE9] half-bridge delays going active by dead-band instruction cycles
// [RULE10] dead-band longer than active time keeps that output inactive
// [RULE11] software clears port direction bits for A and B pins
// [RULE12] forward holds A active modulating D; reverse holds C modulating B
// [RULE13] direction bit writable anytime, applied from the next cycle
// [RULE14] direction change swaps unmodulated outputs four times prescale early
// [RULE15] modulated B and D stay inactive from swap to new period
// [RULE16] full-bridge uses no dead-band delay
// [RULE17] software should lower duty one period before reversing near full
// [RULE18] config from control bits 7:6, mode and polarity from 3:0
// [RULE19] after timer equals period: clear timer, set output, load shadow
// [RULE20] low mode bits pick polarity for A/C pair and B/D pair
// [RULE21] dead-band delays only the inactive to active transition
// [RULE22] field codes: 00 single, 10 half, 01 forward, 11 reverse
module bpwm_output_stage
	import bpwm_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// bridge driver outputs
	output logic             bridgeOutA,
	output logic             bridgeOutB,
	output logic             bridgeOutC,
	output logic             bridgeOutD
);
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [5:0] tickLast(input logic [1:0] ps);
		tickLast = (ps == PS_DIV1) ? LAST_DIV1 : (ps == PS_DIV4) ? LAST_DIV4 : LAST_DIV16;
	endfunction

	// two sub-timer bits that give duty steps of prescale times one oscillator period
	function automatic logic [1:0] fineBits(input logic [5:0] cnt, input logic [1:0] ps);
		fineBits = (ps == PS_DIV1) ? cnt[1:0] : (ps == PS_DIV4) ? cnt[3:2] : cnt[5:4];
	endfunction

	// ****************************************
	// state
	// ****************************************
	logic        hreadyout_r;
	logic [31:0] hrdata_r;
	logic        apWr_r;
	logic        rdPend_r;
	logic [7:0]  apAddr_r;
	logic [7:0]  dutyHigh_r;
	logic [7:0]  ctl_r;
	logic [7:0]  period_r;
	logic [2:0]  tmrCtl_r;
	logic [6:0]  dead_r;
	logic [5:0]  divCnt_r;
	logic [7:0]  tmr_r;
	logic [7:0]  shadow_r;
	logic [1:0]  latch_r;
	logic [1:0]  cfg_r;
	logic [1:0]  pol_r;
	logic        pwmMode_r;
	logic [6:0]  dbBuf_r;
	logic        pwmRaw_r;
	logic [8:0]  dlyA_r;
	logic [8:0]  dlyB_r;
	logic        outA_r;
	logic        outB_r;
	logic        outC_r;
	logic        outD_r;

	// ****************************************
	// bus decode
	// ****************************************
	wire        accept   = hsel && htrans[1] && hready;
	wire        wrDuty   = apWr_r && (apAddr_r == OFS_DUTY_HIGH);
	wire        wrCtl    = apWr_r && (apAddr_r == OFS_CONTROL);
	wire        wrPeriod = apWr_r && (apAddr_r == OFS_PERIOD);
	wire        wrTmrCtl = apWr_r && (apAddr_r == OFS_TIMER_CTL);
	wire        wrDead   = apWr_r && (apAddr_r == OFS_DEADBAND);
	// shadow is read only in every mode; no write strobe exists for it
	wire [7:0]  rdByte   =
		(apAddr_r == OFS_DUTY_HIGH) ? dutyHigh_r :
		(apAddr_r == OFS_CONTROL)   ? ctl_r :
		(apAddr_r == OFS_PERIOD)    ? period_r :
		(apAddr_r == OFS_TIMER_CTL) ? {5'h00, tmrCtl_r} :
		(apAddr_r == OFS_DEADBAND)  ? {1'b0, dead_r} :
		(apAddr_r == OFS_SHADOW)    ? shadow_r :          // RULE3
		(apAddr_r == OFS_TIMER)     ? tmr_r : RST_ZERO8;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			apWr_r      <= 1'b0;
			rdPend_r    <= 1'b0;
			apAddr_r    <= RST_ZERO8;
			hreadyout_r <= 1'b1;
			hrdata_r    <= 32'h0000_0000;
		end else begin
			apWr_r   <= accept && hwrite;
			rdPend_r <= accept && !hwrite;
			if (accept)
				apAddr_r <= haddr[7:0];
			// reads take one wait state so a write just before is seen
			hreadyout_r <= !(accept && !hwrite);
			if (rdPend_r)
				hrdata_r <= {24'h000000, rdByte};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dutyHigh_r <= RST_ZERO8;
			ctl_r      <= RST_ZERO8;
			period_r   <= RST_PERIOD;
			tmrCtl_r   <= 3'h0;
			dead_r     <= 7'h00;
		end else begin
			if (wrDuty)
				dutyHigh_r <= hwdata[7:0];                // RULE1 RULE2
			if (wrCtl)
				ctl_r <= hwdata[7:0];                     // RULE13
			if (wrPeriod)
				period_r <= hwdata[7:0];
			if (wrTmrCtl)
				tmrCtl_r <= hwdata[2:0];
			if (wrDead)
				dead_r <= hwdata[6:0];
		end
	end

	// ****************************************
	// period timer and duty compare
	// ****************************************
	wire        tmrOn      = tmrCtl_r[TMR_ON_BIT];
	wire [1:0]  ps         = tmrCtl_r[1:0];
	wire        tick       = tmrOn && (divCnt_r >= tickLast(ps));        // RULE6
	wire        atPeriod   = (tmr_r == period_r);
	wire        periodStart = tick && atPeriod;                          // RULE19
	wire [9:0]  dutyNew    = {dutyHigh_r, ctl_r[5:4]};                   // RULE1
	// equality only: a duty beyond the period end never matches
	wire        dutyMatch  =
		({tmr_r, fineBits(divCnt_r, ps)} == {shadow_r, latch_r});       // RULE4 RULE5
	wire        clearHit   = pwmRaw_r && dutyMatch;
	// drive drops in the matching step itself, else every pulse is one clock too long
	wire        pwmLive    = pwmRaw_r && !dutyMatch;                    // RULE4
	wire        overBuf    = {shadow_r, latch_r} > {period_r, 2'h3};

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			divCnt_r  <= 6'h00;
			tmr_r     <= RST_ZERO8;
			shadow_r  <= RST_ZERO8;
			latch_r   <= 2'h0;
			cfg_r     <= CFG_SINGLE;
			pol_r     <= 2'h0;
			pwmMode_r <= 1'b0;
			dbBuf_r   <= 7'h00;
			pwmRaw_r  <= 1'b0;
		end else begin
			divCnt_r <= (!tmrOn || tick) ? 6'h00 : divCnt_r + 6'h01;
			if (periodStart)
				tmr_r <= RST_ZERO8;                           // RULE19
			else if (tick)
				tmr_r <= tmr_r + 8'h01;
			if (periodStart) begin
				shadow_r  <= dutyHigh_r;                      // RULE2 RULE19
				latch_r   <= ctl_r[5:4];
				cfg_r     <= ctl_r[7:6];                      // RULE13 RULE18
				pol_r     <= ctl_r[1:0];                      // RULE20
				pwmMode_r <= (ctl_r[3:2] == MODE_PWM);        // RULE18
				pwmRaw_r  <= (dutyNew != 10'h000);            // RULE19
			end else if (clearHit)
				pwmRaw_r <= 1'b0;                             // RULE4
			// delay count follows at whichever boundary comes first
			if (periodStart || clearHit)
				dbBuf_r <= dead_r;
		end
	end

	// ****************************************
	// dead-band: count clocks of a rising target only
	// ****************************************
	wire [8:0]  dlyTarget = {dbBuf_r, 2'h0};                          // RULE9
	wire        aHalf     = pwmLive && (dlyA_r == dlyTarget);         // RULE21
	wire        bHalf     = !pwmLive && (dlyB_r == dlyTarget);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dlyA_r <= 9'h000;
			dlyB_r <= 9'h000;
		end else begin
			// falling target restarts the count, so a short pulse never shows
			dlyA_r <= !pwmLive ? 9'h000 :
				(dlyA_r < dlyTarget) ? dlyA_r + 9'h001 : dlyA_r;     // RULE10
			dlyB_r <= pwmLive ? 9'h000 :
				(dlyB_r < dlyTarget) ? dlyB_r + 9'h001 : dlyB_r;     // RULE10
		end
	end

	// ****************************************
	// output steering
	// ****************************************
	wire        newRev   = ctl_r[CTL_DIR_BIT];
	// pending reversal only while both old and new settings are full-bridge
	wire        dirPend  = cfg_r[0] && ctl_r[CTL_FULL_BIT] &&
		(newRev != cfg_r[1]);                                          // RULE13 RULE22
	wire        swapSlot = pwmMode_r && dirPend && atPeriod;           // RULE14
	wire        isHalf   = (cfg_r == CFG_HALF);                        // RULE7 RULE22
	wire        isFwd    = (cfg_r == CFG_FWD);
	wire        isRev    = (cfg_r == CFG_REV);
	wire        nA = pwmMode_r && (swapSlot ? !newRev :
		isFwd ? 1'b1 : isHalf ? aHalf : isRev ? 1'b0 : pwmLive);       // RULE8 RULE12
	wire        nB = pwmMode_r && !swapSlot &&
		(isHalf ? bHalf : isRev ? pwmLive : 1'b0);                     // RULE8 RULE15
	wire        nC = pwmMode_r && (swapSlot ? newRev : isRev);         // RULE12 RULE14
	wire        nD = pwmMode_r && !swapSlot && isFwd && pwmLive;       // RULE15 RULE16

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			outA_r <= 1'b0;
			outB_r <= 1'b0;
			outC_r <= 1'b0;
			outD_r <= 1'b0;
		end else begin
			outA_r <= nA ^ pol_r[1];                          // RULE20
			outB_r <= nB ^ pol_r[0];
			outC_r <= nC ^ pol_r[1];
			outD_r <= nD ^ pol_r[0];
		end
	end

	assign hreadyout  = hreadyout_r;
	assign hresp      = 1'b0;
	assign hrdata     = hrdata_r;
	assign bridgeOutA = outA_r;
	assign bridgeOutB = outB_r;
	assign bridgeOutC = outC_r;
	assign bridgeOutD = outD_r;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence quietTicks;
		!tick [*3];
	endsequence

	// a nonzero delay keeps the rising output off for at least two clocks
	sequence holdOff;
		!aHalf ##1 !aHalf;
	endsequence

	shadow_load_a: assert property (periodStart |=> // RULE1 RULE2 RULE19
		(shadow_r == $past(dutyHigh_r)) && (latch_r == $past(ctl_r[5:4])))
		else $error("shadow not loaded at period start");
	shadow_ro_a: assert property ( // RULE3
		(apWr_r && apAddr_r == OFS_SHADOW && !periodStart) |=> $stable(shadow_r))
		else $error("shadow changed by software write");
	timer_wrap_a: assert property (periodStart |=> tmr_r == 8'h00) // RULE19
		else $error("timer not cleared after period match");
	tick_gap_a: assert property ((tick && ps == PS_DIV1) |=> quietTicks) // RULE6
		else $error("prescale 1 tick spacing wrong");
	over_duty_a: assert property (overBuf |-> !clearHit) // RULE5
		else $error("over-length duty cleared output");
	half_excl_a: assert property ((pwmMode_r && isHalf) |=> // RULE8
		!((outA_r ^ $past(pol_r[1])) && (outB_r ^ $past(pol_r[0]))))
		else $error("half-bridge outputs active together");
	dead_band_a: assert property ( // RULE9 RULE21
		(pwmMode_r && isHalf && $rose(pwmLive) && dbBuf_r != 7'h00) |-> holdOff)
		else $error("dead-band delay skipped");
	fwd_hold_a: assert property ((pwmMode_r && isFwd && !swapSlot) |=> // RULE12 RULE16
		(outA_r != $past(pol_r[1])) && (outD_r == ($past(pwmLive) ^ $past(pol_r[0]))))
		else $error("forward drive wrong");
	rev_hold_a: assert property ((pwmMode_r && isRev && !swapSlot) |=> // RULE12 RULE16
		(outC_r != $past(pol_r[1])) && (outA_r == $past(pol_r[1])) &&
		(outB_r == ($past(pwmLive) ^ $past(pol_r[0]))))
		else $error("reverse drive wrong");
	mode_off_a: assert property (!pwmMode_r |=> // RULE18 RULE20
		(outA_r == $past(pol_r[1])) && (outB_r == $past(pol_r[0])) &&
		(outC_r == $past(pol_r[1])) && (outD_r == $past(pol_r[0])))
		else $error("outputs driven outside PWM mode");
	swap_idle_a: assert property (swapSlot |=> // RULE14 RULE15
		(outB_r == $past(pol_r[0])) && (outD_r == $past(pol_r[0])) &&
		(outC_r == ($past(newRev) ^ $past(pol_r[1]))))
		else $error("direction swap outputs wrong");
endmodule // bpwm_output_stage

// File: test/bpwm_bridge_drv.sv
// switch-driver model that integrates each bridge input and shoot-through time
`timescale 1ns/100ps
module bpwm_bridge_drv (
	// clock and window control
	input  wire logic        clk,
	input  wire logic        clr,
	// bridge inputs, integrated on every clock while clr is low
	input  wire logic        inA,
	input  wire logic        inB,
	input  wire logic        inC,
	input  wire logic        inD,
	// integrated high times
	output logic      [15:0] highA_r,
	output logic      [15:0] highB_r,
	output logic      [15:0] highC_r,
	output logic      [15:0] highD_r,
	output logic      [15:0] shoot_r
);
	// ****************************************
	// integrators
	// ****************************************
	always_ff @(posedge clk) begin
		if (clr) begin
			highA_r <= 16'h0000;
			highB_r <= 16'h0000;
			highC_r <= 16'h0000;
			highD_r <= 16'h0000;
			shoot_r <= 16'h0000;
		end else begin
			highA_r <= highA_r + 16'(inA);
			highB_r <= highB_r + 16'(inB);
			highC_r <= highC_r + 16'(inC);
			highD_r <= highD_r + 16'(inD);
			// both switches of one leg on: the supply is shorted
			shoot_r <= shoot_r + 16'((inA & inB) | (inC & inD));
		end
	end
endmodule // bpwm_bridge_drv

// File: test/bridge_pwm_output_stage_tb.sv
// self-checking bench for the bridge PWM output stage
`timescale 1ns/100ps
module bridge_pwm_output_stage_tb;
	import bpwm_pkg::*;
	// ****************************************
	// signals, bus tasks and reference model
	// ****************************************
	localparam int PR = 7;
	logic        clk = 1'b0, rst_n = 1'b0, clr = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'h421f2b66;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic        hreadyout, hresp, outA, outB, outC, outD;
	logic [15:0] hiA, hiB, hiC, hiD, shoot;
	int          nErrors = 0, checks = 0;
	always #2.5 clk = ~clk;
	bpwm_output_stage DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.bridgeOutA(outA), .bridgeOutB(outB), .bridgeOutC(outC), .bridgeOutD(outD));
	bpwm_bridge_drv drv (.clk(clk), .clr(clr), .inA(outA), .inB(outB), .inC(outC),
		.inD(outD), .highA_r(hiA), .highB_r(hiB), .highC_r(hiC), .highD_r(hiD),
		.shoot_r(shoot));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			nErrors++;
			$display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(a, 1'b1, d, q);
	endtask
	function automatic int clip(input int v);
		return (v > 0) ? v : 0;
	endfunction
	task automatic run(input logic [1:0] cfg, pol, psc, input int duty, db);
		int ps, p, h, act[4];
		logic [31:0] q;
		ps  = (psc == 2'h0) ? 1 : (psc == 2'h1) ? 4 : 16;
		p   = 4 * (PR + 1) * ps;
		h   = (duty * ps > p) ? p : duty * ps;
		act = '{0, 0, 0, 0};
		case (cfg)
			CFG_SINGLE: act[0] = h;
			CFG_HALF: begin
				act[0] = clip(h - 4 * db);
				act[1] = clip(p - h - 4 * db);
			end
			CFG_FWD: begin
				act[0] = p;
				act[3] = h;
			end
			default: begin
				act[2] = p;
				act[1] = h;
			end
		endcase
		wr(OFS_TIMER_CTL, {29'h0, 1'b1, psc});
		wr(OFS_DEADBAND, 32'(db));
		wr(OFS_DUTY_HIGH, 32'(duty >> 2));
		wr(OFS_CONTROL, {24'h0, cfg, 2'(duty), 2'h3, pol});
		xfer(OFS_CONTROL, 1'b0, 32'h0, q);
		chk("control", q, {24'h0, cfg, 2'(duty), 2'h3, pol});
		repeat (3 * p) @(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		repeat (2 * p) @(posedge clk);
		#1;
		chk("outA", 32'(hiA), 32'(pol[1] ? 2 * (p - act[0]) : 2 * act[0]));
		chk("outB", 32'(hiB), 32'(pol[0] ? 2 * (p - act[1]) : 2 * act[1]));
		chk("outC", 32'(hiC), 32'(pol[1] ? 2 * (p - act[2]) : 2 * act[2]));
		chk("outD", 32'(hiD), 32'(pol[0] ? 2 * (p - act[3]) : 2 * act[3]));
		wr(OFS_SHADOW, 32'hFF);
		xfer(OFS_SHADOW, 1'b0, 32'h0, q);
		chk("shadow", q, 32'(duty >> 2));
	endtask
	task automatic stop_test();
		if (nErrors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial begin
		#300000;
		nErrors++;
		stop_test();
	end
	initial begin
		logic [31:0] q;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		clr   <= 1'b0;
		#1;
		chk("idle outputs", {28'h0, outA, outB, outC, outD}, 32'h0);
		xfer(OFS_PERIOD, 1'b0, 32'h0, q);
		chk("period reset", q, {24'h0, RST_PERIOD});
		xfer(8'h40, 1'b0, 32'h0, q);
		chk("unmapped", q, 32'h0);
		wr(OFS_PERIOD, 32'(PR));
		for (int c = 0; c < 4; c++)
			for (int s = 0; s < 3; s++)
				run(2'(c), 2'(rnd()), 2'(s), 1 + int'(rnd() % 31), int'(rnd() % 4));
		run(CFG_SINGLE, 2'h0, 2'h1, 0, 0);
		run(CFG_SINGLE, 2'h0, 2'h0, 35, 0);
		run(CFG_HALF, 2'h0, 2'h0, 16, 127);
		run(CFG_FWD, 2'h0, 2'h0, 20, 0);
		// lower the duty for a period before reversing
		wr(OFS_DUTY_HIGH, 32'h2);
		repeat (64) @(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		wr(OFS_CONTROL, {24'h0, CFG_REV, 2'h0, 2'h3, 2'h0});
		repeat (96) @(posedge clk);
		#1;
		chk("shoot-through", 32'(shoot), 32'h0);
		// mode bits off with both pairs active-low: every pin rests high
		wr(OFS_CONTROL, {24'h0, CFG_HALF, 2'h0, 2'h0, 2'h3});
		repeat (96) @(posedge clk);
		#1;
		chk("mode off", {28'h0, outA, outB, outC, outD}, 32'hF);
		stop_test();
	end
endmodule // bridge_pwm_output_stage_tb
